// file: core/wdt_pkg.sv
// package: register map, control fields, timing constants and carrier types of the watchdog timer
package wdt_pkg;
   // register byte addresses
   localparam logic [31:0] WDT_RELOAD_ADDR  = 32'hffff0360;
   localparam logic [31:0] WDT_COUNT_ADDR   = 32'hffff0364;
   localparam logic [31:0] WDT_CONTROL_ADDR = 32'hffff0368;
   localparam logic [31:0] WDT_REFRESH_ADDR = 32'hffff036c;

   // reset values
   localparam logic [15:0] WDT_RELOAD_RST  = 16'h0040;
   localparam logic [15:0] WDT_COUNT_RST   = 16'h0040;
   localparam logic [15:0] WDT_CONTROL_RST = 16'h0000;

   // control field positions
   localparam int WDT_CTL_STOP_PD_BIT = 0;
   localparam int WDT_CTL_IRQ_SEL_BIT = 1;
   localparam int WDT_CTL_PRE_LO      = 2;
   localparam int WDT_CTL_PRE_HI      = 3;
   localparam int WDT_CTL_WD_MODE_BIT = 5;
   localparam int WDT_CTL_PERIOD_BIT  = 6;
   localparam int WDT_CTL_ENABLE_BIT  = 7;
   localparam int WDT_CTL_UP_BIT      = 8;
   localparam logic [15:0] WDT_CTL_MASK = 16'h01ef;

   // prescale codes
   localparam logic [1:0] WDT_PRE_DIV1   = 2'h0;
   localparam logic [1:0] WDT_PRE_DIV16  = 2'h1;
   localparam logic [1:0] WDT_PRE_DIV256 = 2'h2;
   localparam logic [7:0] WDT_DIV16_LAST  = 8'h0f;
   localparam logic [7:0] WDT_DIV256_LAST = 8'hff;

   // timing: low-power oscillator and worst-case timeout
   localparam int WDT_LP_OSC_HZ    = 32768;
   localparam int WDT_MAX_TMO_S    = 512;
   localparam int WDT_MAX_TMO_TICKS = WDT_MAX_TMO_S * WDT_LP_OSC_HZ / 256;

   localparam logic [15:0] WDT_COUNT_MAX = 16'hffff;
   localparam logic [15:0] WDT_COUNT_MIN = 16'h0000;

   // register bus request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } wdt_bus_req_t;

   // system-side status and events
   typedef struct packed {
      logic irq;
      logic sys_reset;
      logic capture_valid;
   } wdt_evt_t;
endpackage

// file: core/wdt_timer.sv
// watchdog timer: 16-bit normal/watchdog timer on the low-power oscillator tick
//
// Design decision made here: the strobed register port.
module wdt_timer (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   // register port
   input  wire wdt_pkg::wdt_bus_req_t bus_req,
   output logic [31:0]                bus_rdata,
   // low-power oscillator tick, one ref_clk cycle per 32.768 kHz edge
   input  wire logic                  lp_osc_tick,
   // system conditions
   input  wire logic                  debug_halt,
   input  wire logic                  periph_powerdown,
   input  wire logic                  irq_enable_mask_bit5,
   // events and captured value
   output wdt_pkg::wdt_evt_t          evt,
   output logic [15:0]                capture_value
);
   import wdt_pkg::*;

   logic        rst_sync1_q, rst_sync2_q;
   logic [15:0] reload_q, count_q, count_d, control_q, capture_q;
   logic        ctl_written_q, irq_q, sysrst_q, capv_q;
   logic [7:0]  pre_cnt_q;
   logic [31:0] rdata_q;
   logic        wr_reload, wr_control, wr_refresh, rd_any;
   logic        locked, run, tick_en, div_tick, expire;
   logic [1:0]  pre_sel;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end

   // decode
   assign locked     = control_q[WDT_CTL_WD_MODE_BIT];
   assign wr_reload  = bus_req.wr && bus_req.addr == WDT_RELOAD_ADDR && !locked;
   assign wr_control = bus_req.wr && bus_req.addr == WDT_CONTROL_ADDR
                       && !ctl_written_q && !locked;
   assign wr_refresh = bus_req.wr && bus_req.addr == WDT_REFRESH_ADDR;
   assign rd_any     = bus_req.rd;

   // control: accepted once after reset
   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         control_q     <= WDT_CONTROL_RST;
         ctl_written_q <= 1'b0;
      end else if (wr_control) begin
         control_q     <= bus_req.wdata[15:0] & WDT_CTL_MASK;
         ctl_written_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         reload_q <= WDT_RELOAD_RST;
      end else if (wr_reload) begin
         reload_q <= bus_req.wdata[15:0];
      end
   end

   // prescaler on the oscillator tick; halted while debug owns the core
   assign pre_sel = control_q[WDT_CTL_PRE_HI:WDT_CTL_PRE_LO];
   assign run     = control_q[WDT_CTL_ENABLE_BIT] && !debug_halt
                    && !(control_q[WDT_CTL_STOP_PD_BIT] && periph_powerdown);
   assign tick_en = run && lp_osc_tick;

   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         pre_cnt_q <= 8'h00;
      end else if (wr_control || wr_refresh) begin
         pre_cnt_q <= 8'h00;
      end else if (tick_en) begin
         pre_cnt_q <= div_tick ? 8'h00 : pre_cnt_q + 8'h01;
      end
   end

   // reserved code 11 never ticks
   always_comb begin
      case (pre_sel)
         WDT_PRE_DIV1:   div_tick = tick_en;
         WDT_PRE_DIV16:  div_tick = tick_en && pre_cnt_q == WDT_DIV16_LAST;
         WDT_PRE_DIV256: div_tick = tick_en && pre_cnt_q == WDT_DIV256_LAST;
         default:        div_tick = 1'b0;
      endcase
   end

   // expiry: watchdog always counts down to zero
   always_comb begin
      if (locked) begin
         expire = div_tick && count_q == WDT_COUNT_MIN + 16'h0001;
      end else if (control_q[WDT_CTL_UP_BIT]) begin
         expire = div_tick && count_q == WDT_COUNT_MAX;
      end else begin
         expire = div_tick && count_q == WDT_COUNT_MIN;
      end
   end

   always_comb begin
      count_d = count_q;
      if (wr_refresh) begin
         count_d = reload_q;
      end else if (div_tick) begin
         if (locked) begin
            count_d = (count_q == WDT_COUNT_MIN) ? reload_q : count_q - 16'h0001;
         end else if (expire && control_q[WDT_CTL_PERIOD_BIT]) begin
            count_d = reload_q;
         end else if (control_q[WDT_CTL_UP_BIT]) begin
            count_d = count_q + 16'h0001;
         end else begin
            count_d = count_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         count_q <= WDT_COUNT_RST;
      end else if (wr_control && bus_req.wdata[WDT_CTL_WD_MODE_BIT]) begin
         count_q <= reload_q;
      end else begin
         count_q <= count_d;
      end
   end

   // interrupt flag: set wins over the clear write
   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         irq_q <= 1'b0;
      end else if (expire && (!locked || control_q[WDT_CTL_IRQ_SEL_BIT])) begin
         irq_q <= 1'b1;
      end else if (wr_refresh) begin
         irq_q <= 1'b0;
      end
   end

   // watchdog reset request, held until the system reset clears the block
   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         sysrst_q <= 1'b0;
      end else if (locked && expire && !control_q[WDT_CTL_IRQ_SEL_BIT]) begin
         sysrst_q <= 1'b1;
      end
   end

   // capture in normal mode when the mask bit enables it
   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         capture_q <= 16'h0000;
         capv_q    <= 1'b0;
      end else begin
         capv_q <= 1'b0;
         if (!locked && expire && irq_enable_mask_bit5) begin
            capture_q <= count_q;
            capv_q    <= 1'b1;
         end
      end
   end

   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
      if (!rst_sync2_q) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_any) begin
         case (bus_req.addr)
            WDT_RELOAD_ADDR:  rdata_q <= {16'h0000, reload_q};
            WDT_COUNT_ADDR:   rdata_q <= {16'h0000, count_q};
            WDT_CONTROL_ADDR: rdata_q <= {16'h0000, control_q};
            default:          rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign bus_rdata         = rdata_q;
   assign evt.irq           = irq_q;
   assign evt.sys_reset     = sysrst_q;
   assign evt.capture_valid = capv_q;
   assign capture_value     = capture_q;
endmodule

// file: verification/testbench.sv
// testbench: register-level tests of the watchdog timer
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   logic         ref_clk = 1'b0, resetn = 1'b0, tick = 1'b0, halt = 1'b0, pd = 1'b0, mask = 1'b0;
   logic [1:0]   tc = 2'h0;
   int           failures = 0, n_checks = 0, cyc = 0;
   wdt_bus_req_t req = '0;
   logic [31:0]  rdata, v, w;
   logic [15:0]  capv;
   wdt_evt_t     evt;
   wdt_timer u_wdt_timer (.ref_clk(ref_clk), .resetn(resetn), .bus_req(req), .bus_rdata(rdata),
      .lp_osc_tick(tick), .debug_halt(halt), .periph_powerdown(pd),
      .irq_enable_mask_bit5(mask), .evt(evt), .capture_value(capv));
   always #5 ref_clk = ~ref_clk;
   // oscillator tick every fourth cycle keeps timeouts short
   always @(posedge ref_clk) begin
      tc <= tc + 2'h1;
      tick <= (tc == 2'h3);
      cyc <= cyc + 1;
      // all scenarios together need about 4400 cycles
      if (cyc == 6000) begin
         failures = failures + 1;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (failures == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      @(posedge ref_clk);
      d = rdata;
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
      rd(a, v);
      chk(nm, exp, v);
   endtask
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic wait_evt(input int n);
      for (int i = 0; i < n && evt.irq !== 1'b1 && evt.sys_reset !== 1'b1; i++)
         @(posedge ref_clk);
   endtask
   initial begin
      do_reset();
      rdc("reload", WDT_RELOAD_ADDR, 32'h40);
      rdc("count", WDT_COUNT_ADDR, 32'h40);
      rdc("control", WDT_CONTROL_ADDR, 32'h0);
      rdc("unmapped", 32'hffff0370, 32'h0);
      wr(WDT_COUNT_ADDR, 32'h1234);
      rdc("count ro", WDT_COUNT_ADDR, 32'h40);
      wr(WDT_RELOAD_ADDR, 32'h5);
      mask <= 1'b1;
      halt <= 1'b1;
      wr(WDT_CONTROL_ADDR, 32'hc0);
      wr(WDT_CONTROL_ADDR, 32'h0);
      rdc("control once", WDT_CONTROL_ADDR, 32'hc0);
      wr(WDT_REFRESH_ADDR, 32'h0);
      rdc("refresh load", WDT_COUNT_ADDR, 32'h5);
      repeat (20) @(posedge ref_clk);
      rdc("halted", WDT_COUNT_ADDR, 32'h5);
      halt <= 1'b0;
      wait_evt(100);
      chk("irq", 32'h1, evt.irq);
      repeat (10) @(posedge ref_clk);
      chk("irq held", 32'h1, evt.irq);
      wr(WDT_REFRESH_ADDR, 32'h0);
      chk("irq clear", 32'h0, evt.irq);
      pd <= 1'b1;
      rd(WDT_COUNT_ADDR, w);
      repeat (8) @(posedge ref_clk);
      rd(WDT_COUNT_ADDR, v);
      chk("pd counting", 32'h1, 32'(v != w));
      pd <= 1'b0;
      do_reset();
      wr(WDT_RELOAD_ADDR, 32'h8);
      wr(WDT_CONTROL_ADDR, 32'ha0);
      wr(WDT_RELOAD_ADDR, 32'h3);
      rdc("wd lock", WDT_RELOAD_ADDR, 32'h8);
      repeat (6) begin
         repeat (16) @(posedge ref_clk);
         wr(WDT_REFRESH_ADDR, 32'h0);
      end
      chk("wd serviced", 32'h0, evt.sys_reset);
      wait_evt(100);
      chk("wd reset", 32'h1, evt.sys_reset);
      do_reset();
      // 984 ticks is just over 30 ms of oscillator time
      wr(WDT_RELOAD_ADDR, 32'h3d8);
      wr(WDT_CONTROL_ADDR, 32'ha2);
      repeat (3900) @(posedge ref_clk);
      chk("wd irq early", 32'h0, evt.irq);
      wait_evt(200);
      chk("wd irq", 32'h3, {evt.irq, ~evt.sys_reset});
      do_reset();
      wr(WDT_RELOAD_ADDR, 32'h1);
      wr(WDT_CONTROL_ADDR, 32'hc4);
      wr(WDT_REFRESH_ADDR, 32'h0);
      repeat (60) @(posedge ref_clk);
      chk("div16 early", 32'h0, evt.irq);
      wait_evt(300);
      chk("div16 expiry", 32'h1, evt.irq);
      do_reset();
      pd <= 1'b1;
      wr(WDT_RELOAD_ADDR, 32'hfffd);
      wr(WDT_CONTROL_ADDR, 32'h181);
      wr(WDT_REFRESH_ADDR, 32'h5a);
      repeat (12) @(posedge ref_clk);
      rdc("pd stopped", WDT_COUNT_ADDR, 32'hfffd);
      pd <= 1'b0;
      wait_evt(100);
      chk("up expiry", 32'h1, evt.irq);
      chk("capture", 32'hffff, capv);
      rdc("free wrap", WDT_COUNT_ADDR, 32'h0);
      print_verdict();
   end
endmodule

// file: verification/wdt_timer_asserts.sv
// checker: port-level assertions for the watchdog timer
module wdt_timer_asserts (
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  resetn,
   // observed ports
   input wire wdt_pkg::wdt_bus_req_t bus_req,
   input wire logic [31:0]           bus_rdata,
   input wire logic                  lp_osc_tick,
   input wire logic                  debug_halt,
   input wire logic                  periph_powerdown,
   input wire logic                  irq_enable_mask_bit5,
   input wire wdt_pkg::wdt_evt_t     evt,
   input wire logic [15:0]           capture_value
);
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic hit;
   logic clr_wr;
   assign hit = bus_req.addr inside {WDT_RELOAD_ADDR, WDT_COUNT_ADDR, WDT_CONTROL_ADDR};
   assign clr_wr = bus_req.wr && (bus_req.addr == WDT_REFRESH_ADDR);
   // three cycles without a counting step leave no room for a new expiry
   sequence s_quiet;
      (debug_halt || !lp_osc_tick) [*3];
   endsequence
   a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_reg_width: assert property (bus_req.rd && hit |=> bus_rdata[31:16] == 16'h0)
      else $error("register read wider than 16 bits");
   a_unmapped_zero: assert property (bus_req.rd && !hit |=> bus_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_reset_sticky: assert property (evt.sys_reset |=> evt.sys_reset)
      else $error("reset request dropped");
   a_irq_sticky: assert property (evt.irq && !clr_wr |=> evt.irq)
      else $error("interrupt dropped without clear write");
   a_quiet_hold: assert property (s_quiet |=> !$rose(evt.irq) && !$rose(evt.sys_reset))
      else $error("expiry without a counting step");
   a_capture_pulse: assert property (evt.capture_valid |=> !evt.capture_valid)
      else $error("capture strobe longer than one cycle");
   sequence s_capture;
      $rose(evt.capture_valid);
   endsequence
   a_capture_mask: assert property (s_capture |-> $past(irq_enable_mask_bit5) && evt.irq)
      else $error("capture without enable or expiry");
endmodule

bind wdt_timer wdt_timer_asserts u_wdt_timer_asserts (.ref_clk(ref_clk), .resetn(resetn),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .lp_osc_tick(lp_osc_tick),
   .debug_halt(debug_halt), .periph_powerdown(periph_powerdown),
   .irq_enable_mask_bit5(irq_enable_mask_bit5), .evt(evt), .capture_value(capture_value));
